// *** logic/adc_regs_pkg.sv ***
// Purpose: Shared constants for the converter result and trigger register block
// Assumes: 32-bit Avalon-MM data, one register per aligned word
// Notes:   Byte address of a register is four times its index
package adc_regs_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_RESULT_LOW = 8'h00;
    localparam logic [7:0] IDX_RESULT_HIGH = 8'h01;
    localparam logic [7:0] IDX_CONTROL_B = 8'h02;
    localparam logic [7:0] IDX_CONTROL_A = 8'h03;
    localparam logic [7:0] IDX_PIN_VALUE = 8'h04;
    localparam logic [7:0] IDX_DISABLE_0 = 8'h60;
    localparam logic [7:0] IDX_DISABLE_1 = 8'h61;
    localparam logic [7:0] IDX_DISABLE_2 = 8'h62;

    localparam logic [ADDR_W-1:0] ADDR_RESULT_LOW = {IDX_RESULT_LOW, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_RESULT_HIGH = {IDX_RESULT_HIGH, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_CONTROL_B = {IDX_CONTROL_B, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_CONTROL_A = {IDX_CONTROL_A, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_PIN_VALUE = {IDX_PIN_VALUE, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_DISABLE_0 = {IDX_DISABLE_0, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_DISABLE_1 = {IDX_DISABLE_1, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_DISABLE_2 = {IDX_DISABLE_2, 2'b00};

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int RESULT_W = 10;
    localparam int PIN_W = 15;
    localparam int CTLB_LEFT_ADJUST = 3;
    localparam int CTLB_SOURCE_LSB = 0;
    localparam int CTLA_CONVERTER_ENABLE = 7;
    localparam int CTLA_START = 6;
    localparam int CTLA_AUTO_TRIGGER = 5;
    localparam int CTLA_COMPLETE_FLAG = 4;
    localparam int DIS1_USED_W = 4;
    localparam int DIS2_USED_W = 3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CONTROL_B = 8'h00;
    localparam logic [7:0] RST_DISABLE = 8'h00;
    localparam logic [RESULT_W-1:0] RST_RESULT = 10'h000;

    // ------------------------------------------------------------
    // Trigger source codes
    // ------------------------------------------------------------
    localparam logic [2:0] SRC_FREE_RUNNING = 3'h0;
    localparam logic [2:0] SRC_COMPARATOR = 3'h1;
    localparam logic [2:0] SRC_EXT_INT0 = 3'h2;
    localparam logic [2:0] SRC_T0_COMPARE_A = 3'h3;
    localparam logic [2:0] SRC_T0_OVERFLOW = 3'h4;
    localparam logic [2:0] SRC_T1_COMPARE_B = 3'h5;
    localparam logic [2:0] SRC_T1_OVERFLOW = 3'h6;
    localparam logic [2:0] SRC_T1_CAPTURE = 3'h7;

    // ------------------------------------------------------------
    // Bus handshake states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_t;

endpackage

// *** logic/sync_two_flop.sv ***
// Purpose: Two-flop synchroniser for a vector of pin levels
// Assumes: Each bit is an independent slow level
// Notes:   Only the second stage may be read outside
`timescale 1ns/100ps
`default_nettype none
module sync_two_flop #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    // Next values of both stages
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // First stage feeds the second and nothing else
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule // sync_two_flop
`default_nettype wire

// *** logic/trigger_edge.sv ***
// Purpose: Selects one trigger flag and reports its rising edge
// Assumes: Flags come from logic on mclk
// Notes:   Flag 0 is the conversion-complete flag (free running)
`timescale 1ns/100ps
`default_nettype none
module trigger_edge
    import adc_regs_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [7:0] flags,
    input wire logic [2:0] source,
    output logic rise
);

    logic level_q;
    logic level_d;
    logic [2:0] source_q;
    logic [2:0] source_d;
    logic level_now;
    logic to_free_running;

    // Selection, history and edge
    always_comb begin
        level_now = flags[source];
        to_free_running = (source == SRC_FREE_RUNNING) && (source_q != SRC_FREE_RUNNING);
        level_d = level_now;
        source_d = source;
        // Switching from a clear flag onto a set flag is an edge too; switching to free running never is
        rise = level_now && !level_q && !to_free_running;
    end

    // History of the selected level and of the select itself
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            level_q <= 1'b0;
            source_q <= SRC_FREE_RUNNING;
        end else begin
            level_q <= level_d;
            source_q <= source_d;
        end
    end

endmodule // trigger_edge
`default_nettype wire

// *** logic/adc_result_trigger_regs.sv ***
// Purpose: Result, trigger and input-disable registers of a 10-bit converter
// Assumes: Avalon-MM slave with waitrequest; core and flag sources on mclk
// Notes:   Pin levels are synchronised before use
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module adc_result_trigger_regs
    import adc_regs_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [DATA_W-1:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [DATA_W-1:0] readdata,
    output logic waitrequest,
    input wire logic conv_done,
    input wire logic [RESULT_W-1:0] conv_result,
    input wire logic [7:1] trigger_flags,
    input wire logic [PIN_W-1:0] pin_levels,
    output logic conv_start,
    output logic converter_enable,
    output logic [PIN_W-1:0] input_buffer_disable
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    bus_state_t bus_q;
    bus_state_t bus_d;
    logic waitrequest_q;
    logic waitrequest_d;
    logic [DATA_W-1:0] readdata_q;
    logic [DATA_W-1:0] readdata_d;
    logic [DATA_W-1:0] read_word;
    logic wr_commit;
    logic rd_commit;
    logic wr_low;
    logic low_read_open;

    logic [RESULT_W-1:0] result_q;
    logic [RESULT_W-1:0] result_d;
    logic lock_q;
    logic lock_d;
    logic [7:0] result_low_byte;
    logic [7:0] result_high_byte;

    logic left_adjust_select_q;
    logic left_adjust_select_d;
    logic [2:0] trigger_source_select_q;
    logic [2:0] trigger_source_select_d;
    logic converter_enable_q;
    logic converter_enable_d;
    logic auto_trigger_enable_q;
    logic auto_trigger_enable_d;
    logic conversion_complete_flag_q;
    logic conversion_complete_flag_d;
    logic conv_start_q;
    logic conv_start_d;

    logic [7:0] input_disable_0_q;
    logic [7:0] input_disable_0_d;
    logic [DIS1_USED_W-1:0] input_disable_1_q;
    logic [DIS1_USED_W-1:0] input_disable_1_d;
    logic [DIS2_USED_W-1:0] input_disable_2_q;
    logic [DIS2_USED_W-1:0] input_disable_2_d;
    logic [PIN_W-1:0] disable_vec;
    logic [PIN_W-1:0] pins_sync;
    logic [PIN_W-1:0] pin_value;

    logic [7:0] flag_vec;
    logic source_rise;

    // ------------------------------------------------------------
    // Pin synchronisers and trigger edge
    // ------------------------------------------------------------

    // Pins are outside mclk, so two flops before any masking
    sync_two_flop #(
        .W(PIN_W)
    ) u_pin_sync (
        .mclk(mclk),
        .resetn(resetn),
        .async_in(pin_levels),
        .sync_out(pins_sync)
    );

    // Code zero watches our own completion flag
    assign flag_vec = {trigger_flags, conversion_complete_flag_q};

    // Rising edge of the selected flag; the mode gating sits with control A
    trigger_edge u_trigger_edge (
        .mclk(mclk),
        .resetn(resetn),
        .flags(flag_vec),
        .source(trigger_source_select_q),
        .rise(source_rise)
    );

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------

    // Every access gets exactly one wait cycle, then completes
    always_comb begin
        bus_d = bus_q;
        waitrequest_d = 1'b1;
        readdata_d = readdata_q;
        case (bus_q)
            BUS_IDLE: begin
                if (read || write) begin
                    bus_d = BUS_ACK;
                    waitrequest_d = 1'b0;
                    readdata_d = read ? read_word : '0;
                end
            end
            BUS_ACK: begin
                bus_d = BUS_IDLE;
            end
            default: begin
                bus_d = BUS_IDLE;
            end
        endcase
    end

    // Waitrequest and read data are registered, so
    // the answer always trails the request by one edge
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            bus_q <= BUS_IDLE;
            waitrequest_q <= 1'b1;
            readdata_q <= '0;
        end else begin
            bus_q <= bus_d;
            waitrequest_q <= waitrequest_d;
            readdata_q <= readdata_d;
        end
    end

    // Side effects fire only on the edge the master sees waitrequest low
    assign wr_commit = (bus_q == BUS_ACK) && write;
    assign rd_commit = (bus_q == BUS_ACK) && read;
    assign wr_low = wr_commit && byteenable[0];

    // A low-byte read in flight already freezes the result, so the
    // snapshot handed out and the high byte read later stay one pair
    assign low_read_open = read && (address == ADDR_RESULT_LOW);

    // ------------------------------------------------------------
    // Result presentation and read mux
    // ------------------------------------------------------------

    // Alignment is combinational on the stored result, so it acts at once
    always_comb begin
        if (left_adjust_select_q) begin
            result_high_byte = result_q[9:2];
            result_low_byte = {result_q[1:0], 6'h00};
        end else begin
            result_high_byte = {6'h00, result_q[9:8]};
            result_low_byte = result_q[7:0];
        end
    end

    // Disable bits in pin order: channels 11..0, then ain1, ain0, reference
    assign disable_vec = {input_disable_2_q, input_disable_1_q, input_disable_0_q};
    assign pin_value = pins_sync & ~disable_vec;

    // Unmapped addresses read zero; unused upper bits read zero
    always_comb begin
        read_word = '0;
        case (address)
            ADDR_RESULT_LOW: read_word[7:0] = result_low_byte;
            ADDR_RESULT_HIGH: read_word[7:0] = result_high_byte;
            ADDR_CONTROL_B: begin
                read_word[CTLB_LEFT_ADJUST] = left_adjust_select_q;
                read_word[CTLB_SOURCE_LSB +: 3] = trigger_source_select_q;
            end
            ADDR_CONTROL_A: begin
                read_word[CTLA_CONVERTER_ENABLE] = converter_enable_q;
                read_word[CTLA_AUTO_TRIGGER] = auto_trigger_enable_q;
                read_word[CTLA_COMPLETE_FLAG] = conversion_complete_flag_q;
            end
            ADDR_PIN_VALUE: read_word[PIN_W-1:0] = pin_value;
            ADDR_DISABLE_0: read_word[7:0] = input_disable_0_q;
            ADDR_DISABLE_1: read_word[DIS1_USED_W-1:0] = input_disable_1_q;
            ADDR_DISABLE_2: read_word[DIS2_USED_W-1:0] = input_disable_2_q;
            default: read_word = '0;
        endcase
    end

    // ------------------------------------------------------------
    // Result capture and read lock
    // ------------------------------------------------------------

    // A result arriving while locked is dropped, not queued
    always_comb begin
        result_d = result_q;
        lock_d = lock_q;
        if (conv_done && !lock_q && !low_read_open) begin
            result_d = conv_result;
        end
        if (rd_commit && address == ADDR_RESULT_LOW) begin
            lock_d = 1'b1;
        end else if (rd_commit && address == ADDR_RESULT_HIGH) begin
            lock_d = 1'b0;
        end
    end

    // Result and lock registers
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            result_q <= RST_RESULT;
            lock_q <= 1'b0;
        end else begin
            result_q <= result_d;
            lock_q <= lock_d;
        end
    end

    // ------------------------------------------------------------
    // Control registers and trigger
    // ------------------------------------------------------------

    // Bits 7:4 of control B are not stored, so they always read zero
    always_comb begin
        left_adjust_select_d = left_adjust_select_q;
        trigger_source_select_d = trigger_source_select_q;
        converter_enable_d = converter_enable_q;
        auto_trigger_enable_d = auto_trigger_enable_q;
        conversion_complete_flag_d = conversion_complete_flag_q;
        conv_start_d = 1'b0;
        if (wr_low && address == ADDR_CONTROL_B) begin
            left_adjust_select_d = writedata[CTLB_LEFT_ADJUST];
            trigger_source_select_d = writedata[CTLB_SOURCE_LSB +: 3];
        end
        if (wr_low && address == ADDR_CONTROL_A) begin
            converter_enable_d = writedata[CTLA_CONVERTER_ENABLE];
            auto_trigger_enable_d = writedata[CTLA_AUTO_TRIGGER];
            if (writedata[CTLA_COMPLETE_FLAG]) begin
                conversion_complete_flag_d = 1'b0;
            end
            if (writedata[CTLA_START] && writedata[CTLA_CONVERTER_ENABLE]) begin
                conv_start_d = 1'b1;
            end
        end
        // Set after clear so a finish in the clearing cycle is kept
        if (conv_done) begin
            conversion_complete_flag_d = 1'b1;
        end
        // Source edge counts only in auto mode with the converter on
        if (source_rise && auto_trigger_enable_q && converter_enable_q) begin
            conv_start_d = 1'b1;
        end
    end

    // Control bits, completion flag and the start pulse
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            left_adjust_select_q <= RST_CONTROL_B[CTLB_LEFT_ADJUST];
            trigger_source_select_q <= RST_CONTROL_B[CTLB_SOURCE_LSB +: 3];
            converter_enable_q <= 1'b0;
            auto_trigger_enable_q <= 1'b0;
            conversion_complete_flag_q <= 1'b0;
            conv_start_q <= 1'b0;
        end else begin
            left_adjust_select_q <= left_adjust_select_d;
            trigger_source_select_q <= trigger_source_select_d;
            converter_enable_q <= converter_enable_d;
            auto_trigger_enable_q <= auto_trigger_enable_d;
            conversion_complete_flag_q <= conversion_complete_flag_d;
            conv_start_q <= conv_start_d;
        end
    end

    // ------------------------------------------------------------
    // Digital input disable registers
    // ------------------------------------------------------------

    // Only the implemented low bits are stored
    always_comb begin
        input_disable_0_d = input_disable_0_q;
        input_disable_1_d = input_disable_1_q;
        input_disable_2_d = input_disable_2_q;
        if (wr_low && address == ADDR_DISABLE_0) begin
            input_disable_0_d = writedata[7:0];
        end
        if (wr_low && address == ADDR_DISABLE_1) begin
            input_disable_1_d = writedata[DIS1_USED_W-1:0];
        end
        if (wr_low && address == ADDR_DISABLE_2) begin
            input_disable_2_d = writedata[DIS2_USED_W-1:0];
        end
    end

    // Disable bits, cleared only by reset or a write
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            input_disable_0_q <= RST_DISABLE;
            input_disable_1_q <= RST_DISABLE[DIS1_USED_W-1:0];
            input_disable_2_q <= RST_DISABLE[DIS2_USED_W-1:0];
        end else begin
            input_disable_0_q <= input_disable_0_d;
            input_disable_1_q <= input_disable_1_d;
            input_disable_2_q <= input_disable_2_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from flops
    // ------------------------------------------------------------
    assign readdata = readdata_q;
    assign waitrequest = waitrequest_q;
    assign conv_start = conv_start_q;
    assign converter_enable = converter_enable_q;
    assign input_buffer_disable = disable_vec;

endmodule // adc_result_trigger_regs
`default_nettype wire

// *** testbench/adc_regs_chk.sv ***
// Purpose: Port assertions for the result, trigger and disable registers
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bound from the bench top file
`timescale 1ns/100ps
`default_nettype none
module adc_regs_chk
    import adc_regs_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [DATA_W-1:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [DATA_W-1:0] readdata,
    input wire logic waitrequest,
    input wire logic conv_done,
    input wire logic [RESULT_W-1:0] conv_result,
    input wire logic [7:1] trigger_flags,
    input wire logic [PIN_W-1:0] pin_levels,
    input wire logic conv_start,
    input wire logic converter_enable,
    input wire logic [PIN_W-1:0] input_buffer_disable
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    // Bus steps: taken while idle, then exactly one low cycle
    sequence s_taken;
        (read || write) && waitrequest;
    endsequence
    sequence s_answer;
        !waitrequest ##1 waitrequest;
    endsequence
    a_one_wait: assert property (s_taken |=> s_answer)
        else $error("bus answer not one cycle");
    a_reset_clear: assert property (disable iff (1'b0) !resetn |=> waitrequest && !conv_start
        && !converter_enable && input_buffer_disable == '0 && readdata == '0)
        else $error("outputs not cleared by reset");
    a_start_pulse: assert property (conv_start |=> !conv_start)
        else $error("start longer than one cycle");
    a_start_enabled: assert property (conv_start |-> converter_enable || $past(converter_enable))
        else $error("start while converter off");
    a_read_hold: assert property (!$stable(readdata) |-> !waitrequest)
        else $error("read data moved outside an answer");
    a_dis_by_write: assert property (!$stable(input_buffer_disable) |-> $past(write && !waitrequest))
        else $error("buffer disable moved without a write");
    a_en_by_write: assert property (!$stable(converter_enable) |-> $past(write && !waitrequest))
        else $error("enable moved without a write");
    a_upper_zero: assert property (readdata[DATA_W-1:PIN_W] == '0)
        else $error("unused read bits not zero");
endmodule // adc_regs_chk
`default_nettype wire

// *** testbench/conv_core_model.sv ***
// Purpose: Behavioural converter core answering start pulses
// Assumes: Start and done on mclk
// Notes:   Latency set per conversion by the bench
`timescale 1ns/100ps
`default_nettype none
module conv_core_model (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic conv_start,
    input wire logic [3:0] lat,
    input wire logic [9:0] value,
    output logic conv_done,
    output logic [9:0] conv_result
);
    int cnt = 0;
    logic [9:0] held = 10'h000;
    // Conversion lasts lat+1 cycles, done is a single pulse
    always @(posedge mclk) begin
        conv_done <= 1'b0;
        if (!resetn) begin
            cnt <= 0;
        end else if (conv_start) begin
            cnt <= lat + 1;
            held <= value;
        end else if (cnt == 1) begin
            conv_done <= 1'b1;
            cnt <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
    // Inverse outside the pulse so nobody leans on a stale result
    assign conv_result = conv_done ? held : ~held;
endmodule // conv_core_model
`default_nettype wire

// *** testbench/tb_adc_result_trigger_regs.sv ***
// Purpose: Self-checking bench for the converter register block
// Assumes: Core model answers starts; bench drives flags and pins
// Notes:   Fixed seed, so every run is repeatable
`timescale 1ns/100ps
`default_nettype none
module tb_adc_result_trigger_regs
    import adc_regs_pkg::*;
();
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [ADDR_W-1:0] address = '0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [DATA_W-1:0] writedata = '0;
    logic [3:0] byteenable = 4'hf;
    logic [DATA_W-1:0] readdata, rd;
    logic waitrequest, conv_done, conv_start, converter_enable;
    logic [RESULT_W-1:0] conv_result;
    logic [RESULT_W-1:0] value = '0;
    logic [3:0] lat = 4'h2;
    logic [7:1] trigger_flags = '0;
    logic [7:1] m;
    logic [PIN_W-1:0] pin_levels = '0;
    logic [PIN_W-1:0] input_buffer_disable;
    logic [7:0] d0, d1, d2;
    logic [ADDR_W-1:0] addrs [9] = '{ADDR_RESULT_LOW, ADDR_RESULT_HIGH, ADDR_CONTROL_B, ADDR_CONTROL_A,
        ADDR_PIN_VALUE, ADDR_DISABLE_0, ADDR_DISABLE_1, ADDR_DISABLE_2, 10'h3fc};
    integer seed = 32'hc2f21c43;
    int err_total = 0;
    int checks_done = 0;
    int starts = 0;
    int s0;
    // Clock, 40 ns period
    initial forever #20 mclk = ~mclk;
    adc_result_trigger_regs dut_u (.mclk(mclk), .resetn(resetn), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .conv_done(conv_done), .conv_result(conv_result),
        .trigger_flags(trigger_flags), .pin_levels(pin_levels), .conv_start(conv_start),
        .converter_enable(converter_enable), .input_buffer_disable(input_buffer_disable));
    conv_core_model core_u (.mclk(mclk), .resetn(resetn), .conv_start(conv_start), .lat(lat),
        .value(value), .conv_done(conv_done), .conv_result(conv_result));
    // Start pulses counted for the trigger tests
    always @(posedge mclk) if (conv_start === 1'b1) starts <= starts + 1;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One bus access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] wd);
        @(posedge mclk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= {24'h0, wd};
        do begin
            @(posedge mclk);
        end while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        bus(1'b0, a, 8'h00);
        chk(rd, exp);
    endtask
    function automatic logic [31:0] res_lo(logic [9:0] r, logic la);
        return la ? {24'h0, r[1:0], 6'h00} : {24'h0, r[7:0]};
    endfunction
    function automatic logic [31:0] res_hi(logic [9:0] r, logic la);
        return la ? {24'h0, r[9:2]} : {30'h0, r[9:8]};
    endfunction
    // Manual start, wait for the done pulse, slow or prompt at random
    task automatic convert(input logic [9:0] v);
        int n;
        n = 0;
        value <= v;
        lat <= 4'($random(seed));
        bus(1'b1, ADDR_CONTROL_A, 8'hc0);
        while (conv_done !== 1'b1 && n < 40) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 40) err_total++;
        @(posedge mclk);
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Watchdog well past the expected few hundred cycles
    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        final_report;
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [9:0] r1;
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        foreach (addrs[i]) rchk(addrs[i], 32'h0);
        // All-ones corner first, then random disables
        for (int i = 0; i < 2; i++) begin
            {d0, d1, d2} = i ? 24'($random(seed)) : 24'hffffff;
            bus(1'b1, ADDR_DISABLE_0, d0);
            bus(1'b1, ADDR_DISABLE_1, d1);
            bus(1'b1, ADDR_DISABLE_2, d2);
            rchk(ADDR_DISABLE_0, {24'h0, d0});
            rchk(ADDR_DISABLE_1, {28'h0, d1[3:0]});
            rchk(ADDR_DISABLE_2, {29'h0, d2[2:0]});
            chk({17'h0, input_buffer_disable}, {17'h0, d2[2:0], d1[3:0], d0});
            pin_levels <= 15'($random(seed));
            repeat (3) @(posedge mclk);
            rchk(ADDR_PIN_VALUE, {17'h0, pin_levels & ~{d2[2:0], d1[3:0], d0}});
        end
        $display("test disables done");
        r1 = 10'($random(seed));
        convert(r1);
        for (int la = 0; la < 2; la++) begin
            bus(1'b1, ADDR_CONTROL_B, {4'h0, la[0], 3'h0});
            rchk(ADDR_RESULT_LOW, res_lo(r1, la[0]));
            rchk(ADDR_RESULT_HIGH, res_hi(r1, la[0]));
        end
        // Low read locks; result arriving meanwhile is lost
        rchk(ADDR_RESULT_LOW, res_lo(r1, 1'b1));
        convert(~r1);
        rchk(ADDR_RESULT_HIGH, res_hi(r1, 1'b1));
        convert(~r1);
        rchk(ADDR_RESULT_HIGH, res_hi(~r1, 1'b1));
        rchk(ADDR_CONTROL_A, 32'h90);
        $display("test results done");
        bus(1'b1, ADDR_CONTROL_A, 8'hb0);
        for (int c = 1; c < 8; c++) begin
            m = 7'h01 << (c - 1);
            bus(1'b1, ADDR_CONTROL_B, c[7:0]);
            s0 = starts;
            trigger_flags <= ~m;
            repeat (4) @(posedge mclk);
            trigger_flags <= 7'h7f;
            repeat (4) @(posedge mclk);
            trigger_flags <= '0;
            chk(32'(starts - s0), 32'h1);
        end
        bus(1'b1, ADDR_CONTROL_B, 8'h01);
        trigger_flags <= 7'h02;
        repeat (20) @(posedge mclk);
        s0 = starts;
        bus(1'b1, ADDR_CONTROL_B, 8'h02);
        repeat (4) @(posedge mclk);
        chk(32'(starts - s0), 32'h1);
        trigger_flags <= '0;
        repeat (20) @(posedge mclk);
        s0 = starts;
        bus(1'b1, ADDR_CONTROL_B, 8'h00);
        repeat (4) @(posedge mclk);
        chk(32'(starts - s0), 32'h0);
        bus(1'b1, ADDR_CONTROL_A, 8'h80);
        chk({31'h0, converter_enable}, 32'h1);
        bus(1'b1, ADDR_CONTROL_B, 8'h03);
        s0 = starts;
        trigger_flags <= 7'h04;
        repeat (4) @(posedge mclk);
        chk(32'(starts - s0), 32'h0);
        byteenable <= 4'he;
        bus(1'b1, ADDR_DISABLE_0, 8'h5a);
        byteenable <= 4'hf;
        rchk(ADDR_DISABLE_0, {24'h0, d0});
        $display("test triggers done");
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        rchk(ADDR_DISABLE_0, 32'h0);
        $display("test second reset done");
        final_report;
    end
endmodule // tb_adc_result_trigger_regs
bind adc_result_trigger_regs adc_regs_chk chk_u (.mclk(mclk), .resetn(resetn), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .conv_done(conv_done), .conv_result(conv_result),
    .trigger_flags(trigger_flags), .pin_levels(pin_levels), .conv_start(conv_start),
    .converter_enable(converter_enable), .input_buffer_disable(input_buffer_disable));
`default_nettype wire
